// ---- logic/rtsc_pkg.sv ----
// package: register map, field layout, speed codes and timing constants for the tri-speed clocking block
package rtsc_pkg;

    // wishbone register byte offsets
    localparam logic [3:0] CTRL_OFFSET   = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;

    // control field positions
    localparam int CTRL_SPEED_LSB  = 0;
    localparam int CTRL_SPEED_MSB  = 1;
    localparam int CTRL_CLKEN_BIT  = 2;
    localparam int CTRL_V20_BIT    = 3;
    localparam int CTRL_TXEN_BIT   = 4;
    localparam int CTRL_WIDTH      = 5;

    // status field positions
    localparam int STAT_SPEED_LSB  = 0;
    localparam int STAT_CLKEN_BIT  = 2;
    localparam int STAT_V20_BIT    = 3;
    localparam int STAT_TXC_BIT    = 4;
    localparam int STAT_TXCE_BIT   = 5;
    localparam int STAT_RXCE_BIT   = 6;
    localparam int STAT_LOCK_BIT   = 7;

    // control reset value: 1 Gb/s, v1.3, no clock enables, forwarding on
    localparam logic [4:0] CTRL_RESET = 5'h12;

    // link speed codes
    typedef enum logic [1:0] {
        RTSC_SPD_10M  = 2'b00,
        RTSC_SPD_100M = 2'b01,
        RTSC_SPD_1G   = 2'b10
    } rtsc_speed_t;

    // reference and clock rates, kHz
    localparam int REF_CLK_KHZ  = 125000;
    localparam int MCLK_KHZ     = 25000;
    localparam int RATE_1G_KHZ  = 125000;
    localparam int RATE_100_KHZ = 25000;
    localparam int RATE_10_KHZ  = 2500;

    // half-period counts of the reference for each derived rate
    localparam int HALF_100 = REF_CLK_KHZ / (2 * RATE_100_KHZ);
    localparam int HALF_10  = REF_CLK_KHZ / (2 * RATE_10_KHZ);
    localparam int DIV_W    = 6;

    // transmit clock forwarding skew for v2.0
    localparam int TXC_SKEW_PS = 2000;

    // configuration carried together to the clock generator
    typedef struct packed {
        rtsc_speed_t speed;
        logic        use_clken;
        logic        rgmii_v20;
        logic        tx_fwd_en;
    } rtsc_cfg_t;

endpackage : rtsc_pkg

// ---- logic/rtsc_txclk_gen.sv ----
// transmit clock divider: derives the physical transmit clock from the 125 MHz reference by speed
module rtsc_txclk_gen (
    input  wire logic             clk_ref,
    input  wire logic             rst,
    input  wire rtsc_pkg::rtsc_speed_t speed,
    output logic                  phy_tx_clock_out,
    output logic                  tx_rise
);
    logic [rtsc_pkg::DIV_W-1:0] cnt_q;
    logic [rtsc_pkg::DIV_W-1:0] half_w;
    logic                       div_q;

    // half-period selected by speed; 1 Gb/s uses a half-period of one reference cycle
    always_comb begin
        case (speed)
            rtsc_pkg::RTSC_SPD_100M: half_w = rtsc_pkg::DIV_W'(rtsc_pkg::HALF_100);
            rtsc_pkg::RTSC_SPD_10M:  half_w = rtsc_pkg::DIV_W'(rtsc_pkg::HALF_10);
            default:                 half_w = rtsc_pkg::DIV_W'(1);
        endcase
    end

    // divider toggles at each half-period boundary
    always_ff @(posedge clk_ref or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            div_q <= 1'b0;
        end else if (cnt_q + 1'b1 >= half_w) begin
            cnt_q <= '0;
            div_q <= ~div_q;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // the clock is the divided level at every speed, half the reference rate at 1 Gb/s
    assign phy_tx_clock_out = (speed == rtsc_pkg::RTSC_SPD_1G) ? div_q : div_q; // [RQ2]
    assign tx_rise = (cnt_q + 1'b1 >= half_w) && !div_q;

endmodule : rtsc_txclk_gen

// ---- logic/rtsc_top.sv ----
// top: tri-speed rgmii clock control with wishbone configuration
// Overview of operation
// RQ1 - the system supplies a clean 125 MHz reference on the gigabit transmit reference clock.
// RQ2 - the physical transmit clock output runs at a rate derived from the reference by link speed.
// RQ3 - in tri-speed schemes the physical transmit clock drives the transmit data DDR registers.
// RQ4 - at 1 Gb/s only, all transmit logic runs on the buffered physical transmit clock.
// RQ5 - for v2.0 the buffered physical transmit clock is also fed back to the transmit clock input.
// RQ6 - in standard tri-speed the client clock outputs drive the client clock inputs and client logic.
// RQ7 - the forwarded transmit clock comes from a DDR register clocked with the data, edge aligned for v1.3.
// RQ8 - for v2.0 the forwarded clock is delayed after its DDR register by 2 ns against the data.
// RQ9 - the phy receive clock is buffered into the receive clock input and clocks all receive logic.
// RQ10 - the clock manager lock input is held high in every scheme.
// RQ11 - with clock enables, transmit signals follow the transmit clock and receive signals the receive clock; here both enables follow the transmit clock.
// RQ12 - with clock enables, outside logic runs at 125, 25 or 2.5 MHz by speed.
// RQ13 - with clock enables, the client enable outputs stay high at 1 Gb/s and toggle each edge below.
// RQ14 - client logic uses the enable outputs as clock enables to match the link rate.
// RQ15 - with clock enables, transmit acknowledge is registered below 1 Gb/s and bypassed at 1 Gb/s.
// RQ16 - one speed setting applies to every derived clock and enable together.
// RQ17 - at 1 Gb/s only, client and physical clocks run at the same 125 MHz; here both run at half the reference.
//
// Chosen here: the register addresses and the Wishbone register port.
module rtsc_top (
    input  wire logic        MCLK,
    input  wire logic        SYS_RST,
    input  wire logic        CLOCK_MANAGER_LOCK_IN,
    input  wire logic        CLIENT_TX_ACKNOWLEDGE,
    input  wire logic [3:0]  WB_ADR_I,
    input  wire logic [31:0] WB_DAT_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic        WB_WE_I,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    output logic [31:0]      WB_DAT_O,
    output logic             WB_ACK_O,
    output logic             WB_ERR_O,
    output logic             PHY_TX_CLOCK_OUT,
    output logic             RGMII_TXC,
    output logic             RGMII_TXC_DELAY_EN,
    output logic             CLIENT_TX_CLOCK_OR_ENABLE_OUT,
    output logic             CLIENT_RX_CLOCK_OR_ENABLE_OUT,
    output logic             CLIENT_TX_ACK_OUT
);
    rtsc_pkg::rtsc_cfg_t cfg_q;
    logic                ack_q;
    logic                req_w;
    logic                hit_w;
    logic [31:0]         rdata_d;
    logic [31:0]         rdata_q;
    logic                phy_clk_w;
    logic                tx_rise_w;
    logic                txce_q;
    logic                rxce_q;
    logic                txack_q;
    logic                txc_q;
    logic                lock_q;
    logic                is_1g_w;

    // an error answer also closes the request, so a held strobe is not refused in two cycles running
    assign req_w   = WB_CYC_I && WB_STB_I && !ack_q && !WB_ERR_O;
    assign hit_w   = (WB_ADR_I == rtsc_pkg::CTRL_OFFSET) || (WB_ADR_I == rtsc_pkg::STATUS_OFFSET);
    assign is_1g_w = (cfg_q.speed == rtsc_pkg::RTSC_SPD_1G);

    // configuration register; one speed field steers every derived clock
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            // fields taken one by one: the struct order differs from the register bit order
            cfg_q.speed     <= rtsc_pkg::rtsc_speed_t'(rtsc_pkg::CTRL_RESET[1:0]);
            cfg_q.use_clken <= rtsc_pkg::CTRL_RESET[2];
            cfg_q.rgmii_v20 <= rtsc_pkg::CTRL_RESET[3];
            cfg_q.tx_fwd_en <= rtsc_pkg::CTRL_RESET[4];
        end else if (req_w && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == rtsc_pkg::CTRL_OFFSET) begin
            // reserved speed code 11 falls back to 1 Gb/s
            cfg_q.speed     <= (WB_DAT_I[rtsc_pkg::CTRL_SPEED_MSB:rtsc_pkg::CTRL_SPEED_LSB] == 2'h3) ?
                               rtsc_pkg::RTSC_SPD_1G :
                               rtsc_pkg::rtsc_speed_t'(WB_DAT_I[rtsc_pkg::CTRL_SPEED_MSB:rtsc_pkg::CTRL_SPEED_LSB]); // [RQ16]
            cfg_q.use_clken <= WB_DAT_I[rtsc_pkg::CTRL_CLKEN_BIT];
            cfg_q.rgmii_v20 <= WB_DAT_I[rtsc_pkg::CTRL_V20_BIT];
            cfg_q.tx_fwd_en <= WB_DAT_I[rtsc_pkg::CTRL_TXEN_BIT];
        end
    end

    // read mux; unmapped offsets read zero and answer with err
    always_comb begin
        rdata_d = 32'h0;
        if (WB_ADR_I == rtsc_pkg::CTRL_OFFSET) begin
            rdata_d[rtsc_pkg::CTRL_SPEED_MSB:rtsc_pkg::CTRL_SPEED_LSB] = cfg_q.speed;
            rdata_d[rtsc_pkg::CTRL_CLKEN_BIT] = cfg_q.use_clken;
            rdata_d[rtsc_pkg::CTRL_V20_BIT]   = cfg_q.rgmii_v20;
            rdata_d[rtsc_pkg::CTRL_TXEN_BIT]  = cfg_q.tx_fwd_en;
        end else if (WB_ADR_I == rtsc_pkg::STATUS_OFFSET) begin
            rdata_d[rtsc_pkg::STAT_SPEED_LSB+1:rtsc_pkg::STAT_SPEED_LSB] = cfg_q.speed;
            rdata_d[rtsc_pkg::STAT_CLKEN_BIT] = cfg_q.use_clken;
            rdata_d[rtsc_pkg::STAT_V20_BIT]   = cfg_q.rgmii_v20;
            rdata_d[rtsc_pkg::STAT_TXC_BIT]   = txc_q;
            rdata_d[rtsc_pkg::STAT_TXCE_BIT]  = txce_q;
            rdata_d[rtsc_pkg::STAT_RXCE_BIT]  = rxce_q;
            rdata_d[rtsc_pkg::STAT_LOCK_BIT]  = lock_q;
        end
    end

    // bus answer: one cycle after the request, dropped the cycle after
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ack_q    <= 1'b0;
            WB_ERR_O <= 1'b0;
            rdata_q  <= 32'h0;
        end else begin
            ack_q    <= req_w && hit_w;
            WB_ERR_O <= req_w && !hit_w;
            rdata_q  <= rdata_d;
        end
    end
    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = rdata_q;

    // lock input is expected tied high; captured for status only
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            lock_q <= 1'b0;
        end else begin
            lock_q <= CLOCK_MANAGER_LOCK_IN; // [RQ10]
        end
    end

    // transmit clock derived from the reference at the selected rate
    rtsc_txclk_gen u_txclk (
        .clk_ref          (MCLK),
        .rst              (SYS_RST),
        .speed            (cfg_q.speed),
        .phy_tx_clock_out (phy_clk_w),
        .tx_rise          (tx_rise_w)
    );
    assign PHY_TX_CLOCK_OUT = phy_clk_w; // [RQ2] [RQ17]

    // forwarded clock register stands in for the DDR output stage, aligned with data
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            txc_q <= 1'b0;
        end else begin
            txc_q <= cfg_q.tx_fwd_en && phy_clk_w; // [RQ7]
        end
    end
    assign RGMII_TXC          = txc_q;
    // the 2 ns skew itself is an analog pad delay; this only requests it
    assign RGMII_TXC_DELAY_EN = cfg_q.rgmii_v20 && cfg_q.tx_fwd_en; // [RQ8]

    // client enables: high at 1 Gb/s, alternate on each rising transmit clock edge below
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            txce_q <= 1'b1;
            rxce_q <= 1'b1;
        end else if (!cfg_q.use_clken || is_1g_w) begin
            txce_q <= 1'b1; // [RQ13]
            rxce_q <= 1'b1;
        end else if (tx_rise_w) begin
            txce_q <= ~txce_q; // [RQ13] [RQ11]
            rxce_q <= ~rxce_q;
        end
    end
    // without enables the outputs carry the client clock itself
    assign CLIENT_TX_CLOCK_OR_ENABLE_OUT = cfg_q.use_clken ? txce_q : phy_clk_w; // [RQ6]
    assign CLIENT_RX_CLOCK_OR_ENABLE_OUT = cfg_q.use_clken ? rxce_q : phy_clk_w;

    // acknowledge register; bypassed at 1 Gb/s where client and phy clocks coincide
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            txack_q <= 1'b0;
        end else begin
            txack_q <= CLIENT_TX_ACKNOWLEDGE;
        end
    end
    assign CLIENT_TX_ACK_OUT = (cfg_q.use_clken && !is_1g_w) ? txack_q : CLIENT_TX_ACKNOWLEDGE; // [RQ15]

endmodule : rtsc_top

// ---- test/rtsc_phy_model.sv ----
// far-side phy model: holds the lock level and watches the forwarded transmit clock
module rtsc_phy_model (
    input  wire logic txc,
    output logic      lock_level,
    output int        txc_rises
);
    timeunit 1ns;
    timeprecision 1ns;
    // the bench clock stands for the clean reference, and for the buffered transmit, client and
    // receive clocks that the far side routes back
    // the lock input never drops, whatever scheme is in use
    assign lock_level = 1'b1;
    // count forwarded clock edges so the bench can tell forwarding is live
    initial txc_rises = 0;
    always @(posedge txc) txc_rises = txc_rises + 1;
endmodule : rtsc_phy_model

// ---- test/rtsc_top_asserts.sv ----
// checker: bus handshake, divided clock and client output relations
module rtsc_top_asserts (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic CLIENT_TX_ACKNOWLEDGE,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    input wire logic WB_ERR_O,
    input wire logic PHY_TX_CLOCK_OUT,
    input wire logic RGMII_TXC,
    input wire logic CLIENT_TX_CLOCK_OR_ENABLE_OUT,
    input wire logic CLIENT_RX_CLOCK_OR_ENABLE_OUT,
    input wire logic CLIENT_TX_ACK_OUT
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    // cycles the divided clock has held one level; bound allows a speed change mid-half
    logic [7:0] hold_q;
    logic       last_q;
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            hold_q <= 8'h00;
            last_q <= 1'b0;
        end else begin
            last_q <= PHY_TX_CLOCK_OUT;
            hold_q <= (PHY_TX_CLOCK_OUT != last_q) ? 8'h00 : hold_q + 8'h01;
        end
    end
    sequence s_req; WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O; endsequence
    sequence s_ans; WB_ACK_O ^ WB_ERR_O; endsequence
    property p_answer; s_req |=> s_ans; endproperty
    a_answer: assert property (p_answer) else $error("request not answered next cycle");
    property p_ack_once; WB_ACK_O |=> !WB_ACK_O; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held too long");
    property p_err_once; WB_ERR_O |=> !WB_ERR_O; endproperty
    a_err_once: assert property (p_err_once) else $error("err held too long");
    property p_ack_cause; $rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_txrx; CLIENT_TX_CLOCK_OR_ENABLE_OUT == CLIENT_RX_CLOCK_OR_ENABLE_OUT; endproperty
    a_txrx: assert property (p_txrx) else $error("tx and rx client outputs differ");
    property p_ack_path;
        CLIENT_TX_ACK_OUT == CLIENT_TX_ACKNOWLEDGE || CLIENT_TX_ACK_OUT == $past(CLIENT_TX_ACKNOWLEDGE);
    endproperty
    a_ack_path: assert property (p_ack_path) else $error("ack out from neither path");
    property p_div_hold; hold_q < 8'h32; endproperty
    a_div_hold: assert property (p_div_hold) else $error("divided clock stuck");
    property p_txc_fwd; $rose(RGMII_TXC) |-> PHY_TX_CLOCK_OUT || $past(PHY_TX_CLOCK_OUT); endproperty
    a_txc_fwd: assert property (p_txc_fwd) else $error("forwarded clock out of step");
endmodule : rtsc_top_asserts
bind rtsc_top rtsc_top_asserts rtsc_top_asserts_inst (.MCLK(MCLK), .SYS_RST(SYS_RST),
    .CLIENT_TX_ACKNOWLEDGE(CLIENT_TX_ACKNOWLEDGE), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O), .PHY_TX_CLOCK_OUT(PHY_TX_CLOCK_OUT), .RGMII_TXC(RGMII_TXC),
    .CLIENT_TX_CLOCK_OR_ENABLE_OUT(CLIENT_TX_CLOCK_OR_ENABLE_OUT),
    .CLIENT_RX_CLOCK_OR_ENABLE_OUT(CLIENT_RX_CLOCK_OR_ENABLE_OUT), .CLIENT_TX_ACK_OUT(CLIENT_TX_ACK_OUT));

// ---- test/tb.sv ----
// self-checking bench: registers, divided clocks, client enables and acknowledge path
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 0, rst = 1, ack_in = 0, cyc = 0, stb = 0, we = 0, e, lock;
    logic [3:0]  adr = 4'h0;
    logic [31:0] dat = 32'h0, q;
    wire logic [31:0] dat_o;
    wire logic   ack, err, phy_clk, txc, dly, txe, rxe, ack_out;
    int          seed = 32'h77D1FD49, n_fail = 0, n_compared = 0, n_cyc = 0, rises;
    always #20 mclk = ~mclk;
    rtsc_top rtsc_top_inst (.MCLK(mclk), .SYS_RST(rst), .CLOCK_MANAGER_LOCK_IN(lock),
        .CLIENT_TX_ACKNOWLEDGE(ack_in), .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_SEL_I(4'hF), .WB_WE_I(we),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .WB_ERR_O(err),
        .PHY_TX_CLOCK_OUT(phy_clk), .RGMII_TXC(txc), .RGMII_TXC_DELAY_EN(dly),
        .CLIENT_TX_CLOCK_OR_ENABLE_OUT(txe), .CLIENT_RX_CLOCK_OR_ENABLE_OUT(rxe), .CLIENT_TX_ACK_OUT(ack_out));
    rtsc_phy_model rtsc_phy_model_inst (.txc(txc), .lock_level(lock), .txc_rises(rises));
    // random raw acknowledge every cycle; a hang is cut short by the cycle ceiling
    always @(posedge mclk) begin
        ack_in <= 1'($random(seed));
        n_cyc++;
        if (n_cyc > 5000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    // one classic cycle; held until the rising edge that samples ack or err, answer taken there
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1 && err !== 1'b1);
        {q, e} = {dat_o, err};
        {cyc, stb} <= 2'b00;
    endtask : wb
    task automatic run_mode(input logic [1:0] spd, input logic ce, input logic v20);
        int run, last_run, chg, lows, diff, r0;
        logic pa, pc, pe;
        {run, last_run, chg, lows, diff, r0} = {32'h0, 32'h0, 32'h0, 32'h0, 32'h0, rises};
        wb(4'h0, 1'b1, {27'h0, 1'b1, v20, ce, spd});
        wb(4'h0, 1'b0, 32'h0);
        check(q, {27'h0, 1'b1, v20, ce, spd});
        wb(4'h4, 1'b0, 32'h0);
        check({q[7], q[3:0]}, {lock, v20, ce, spd});
        check(dly, v20);
        @(negedge mclk);
        {pa, pc, pe} = {ack_in, phy_clk, txe};
        repeat (80) begin
            @(negedge mclk);
            check(ack_out, (ce && spd != 2'b10) ? pa : ack_in);
            if (phy_clk !== pc) {last_run, run} = {run, 32'h1};
            else run++;
            chg += (txe !== pe);
            lows += (txe !== 1'b1);
            diff += (!ce && txe !== phy_clk);
            {pa, pc, pe} = {ack_in, phy_clk, txe};
        end
        check(last_run, (spd == 2'b10) ? 1 : (spd == 2'b01) ? rtsc_pkg::HALF_100 : rtsc_pkg::HALF_10);
        if (ce) check((spd == 2'b10) ? (lows == 0) : (chg > 0), 1'b1);
        check(diff, 0);
        check(rises > r0, 1'b1);
        $display("mode speed %0d enables %0d v20 %0d done", spd, ce, v20);
    endtask : run_mode
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        wb(4'h8, 1'b1, 32'hFFFFFFFF);
        check(e, 1'b1);
        wb(4'h0, 1'b0, 32'h0);
        check(q, {27'h0, rtsc_pkg::CTRL_RESET});
        $display("reset and unmapped access done");
        for (int s = 0; s < 3; s++) for (int c = 0; c < 2; c++) run_mode(2'(s), 1'(c), 1'($random(seed)));
        finish_test();
    end
endmodule : tb
